// ==== msp_pkg.sv ====
// Purpose: Shared constants, register map and types of the multibuffer serial port
// Assumes: 32-bit classic Wishbone, byte addresses, 16-bit registers in the low lanes
// Notes:   Buffer RAM window: entry in address bits 11:4, field in bits 3:2
package msp_pkg;

  // Bus geometry
  localparam int ADR_W = 13;
  localparam int DAT_W = 32;

  // Register byte addresses
  localparam logic [12:0] ADR_CTRL   = 13'h0000;
  localparam logic [12:0] ADR_STATUS = 13'h0004;
  localparam logic [12:0] ADR_TRIG   = 13'h0008;
  localparam logic [12:0] ADR_RXHOLD = 13'h000c;
  localparam logic [12:0] ADR_GPIO   = 13'h0010;
  localparam logic [12:0] ADR_GRP0   = 13'h0020;
  localparam logic [12:0] ADR_RAM    = 13'h1000;
  localparam int          GRP_STRIDE = 4;

  // Buffer memory and transfer groups
  localparam int ENTRIES  = 256;
  localparam int IDX_W    = 8;
  localparam int GROUPS   = 4;
  localparam int GRP_W    = 2;
  localparam int WORD_W   = 16;

  // Buffer entry fields
  localparam logic [1:0] FLD_TX   = 2'h0;
  localparam logic [1:0] FLD_RX   = 2'h1;
  localparam logic [1:0] FLD_CTL  = 2'h2;
  localparam logic [1:0] FLD_STAT = 2'h3;

  // Control register fields
  localparam int CTRL_EN     = 0;
  localparam int CTRL_MASTER = 1;
  localparam int CTRL_BAUD_L = 8;
  localparam logic [15:0] CTRL_RST = 16'h0000;

  // Status register fields
  localparam int STAT_BUSY  = 0;
  localparam int STAT_DONE  = 1;
  localparam int STAT_CUR_L = 8;

  // Entry status field: bit 0 marks a received word
  localparam logic [15:0] ENT_RXVALID = 16'h0001;

  // GPIO register fields
  localparam int GPIO_OUT_L = 0;
  localparam int GPIO_DIR_L = 4;
  localparam int GPIO_IN_L  = 8;
  localparam int PINS       = 3;

  // Word length limits
  localparam logic [3:0] LEN_M1_MIN = 4'h1;

  // Per-word format held in an entry control field
  typedef struct packed {
    logic [9:0] unused;
    logic       cpha;
    logic       cpol;
    logic [3:0] len_m1;
  } msp_fmt_t;

  // Serial pins, one bit each
  typedef struct packed {
    logic master_in_serial_line;
    logic master_out_serial_line;
    logic serial_shift_clock;
  } msp_pin_t;

  // Sequencer states
  typedef enum logic [4:0] {
    SQ_IDLE  = 5'b00001,
    SQ_LOAD  = 5'b00010,
    SQ_FIRE  = 5'b00100,
    SQ_RUN   = 5'b01000,
    SQ_STORE = 5'b10000
  } msp_seq_t;

endpackage

// ==== msp_shifter.sv ====
// Purpose: Shifts one word of 2 to 16 bits as clock master or slave
// Assumes: sclk_in and sdi are already synchronised to core_clk
// Notes:   MSB first; half bit time in master mode is baud+1 core cycles
`timescale 1ns/1ps
module msp_shifter
  import msp_pkg::*;
(
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               rst_n,
  // Word request
  input  wire logic               start,
  input  wire logic               master,
  input  wire msp_pkg::msp_fmt_t  fmt,
  input  wire logic [7:0]         baud,
  input  wire logic [15:0]        tx_word,
  // Word answer
  output logic                    busy,
  output logic                    done,
  output logic [15:0]             rx_word,
  // Serial side
  input  wire logic               sclk_in,
  input  wire logic               sdi,
  output logic                    sclk_out,
  output logic                    sdo
);

  import msp_pkg::*;

  logic        busy_r;
  logic        done_r;
  logic [5:0]  edge_r;
  logic [7:0]  div_r;
  logic        sclk_r;
  logic        sclk_prev_r;
  logic [15:0] sh_r;
  logic [15:0] rx_r;
  logic [15:0] rx_word_r;
  msp_fmt_t    fmt_r;

  // Edge timing and phase decode
  wire logic [3:0]  len_m1   = (fmt.len_m1 < LEN_M1_MIN) ? LEN_M1_MIN : fmt.len_m1;
  wire logic [5:0]  last_e   = {1'b0, fmt_r.len_m1, 1'b1};
  wire logic        tick     = busy_r & (master ? (div_r == baud) : (sclk_in != sclk_prev_r));
  wire logic        leading  = ~edge_r[0];
  wire logic        sample   = fmt_r.cpha ? ~leading : leading;
  wire logic        skip_sh  = fmt_r.cpha & (edge_r == 6'h00);
  wire logic [15:0] rx_nxt   = {rx_r[14:0], sdi};
  wire logic [15:0] tx_align = tx_word << (4'hf - len_m1);

  // Word shifter; divider gives the bit rate, slave follows the outside clock
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_r      <= 1'b0;
      done_r      <= 1'b0;
      edge_r      <= 6'h00;
      div_r       <= 8'h00;
      sclk_r      <= 1'b0;
      sclk_prev_r <= 1'b0;
      sh_r        <= 16'h0000;
      rx_r        <= 16'h0000;
      rx_word_r   <= 16'h0000;
      fmt_r       <= '0;
    end else begin
      sclk_prev_r <= sclk_in;
      done_r      <= 1'b0;
      if (start && !busy_r) begin
        busy_r       <= 1'b1;
        fmt_r        <= fmt;
        fmt_r.len_m1 <= len_m1;
        edge_r       <= 6'h00;
        div_r        <= 8'h00;
        sclk_r       <= fmt.cpol;
        sh_r         <= tx_align;
        rx_r         <= 16'h0000;
      end else if (busy_r) begin
        div_r <= tick ? 8'h00 : div_r + 8'h01;
        if (tick) begin
          sclk_r <= ~sclk_r;
          edge_r <= edge_r + 6'h01;
          if (sample)
            rx_r <= rx_nxt;
          else if (!skip_sh)
            sh_r <= {sh_r[14:0], 1'b0};
          if (edge_r == last_e) begin
            busy_r    <= 1'b0;
            done_r    <= 1'b1;
            rx_word_r <= sample ? rx_nxt : rx_r;
          end
        end
      end
    end
  end

  assign busy     = busy_r;
  assign done     = done_r;
  assign rx_word  = rx_word_r;
  assign sclk_out = busy_r ? sclk_r : fmt_r.cpol;
  assign sdo      = sh_r[15];

endmodule

// ==== msp_port.sv ====
// Purpose: Multibuffer serial port with Wishbone registers and 256-entry buffer RAM
// Assumes: Pins are asynchronous to core_clk; master or slave chosen in CTRL
// Notes:   A group runs its entries in order from first to last index
//
// Local design decisions: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
module msp_port
  import msp_pkg::*;
(
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               reset_n,
  // Wishbone slave
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [ADR_W-1:0]   wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [DAT_W-1:0]   wb_dat_i,
  output logic      [DAT_W-1:0]   wb_dat_o,
  output logic                    wb_ack_o,
  // Serial pins
  input  wire msp_pkg::msp_pin_t  pin_in,
  output msp_pkg::msp_pin_t       pin_out,
  output msp_pkg::msp_pin_t       pin_oe
);

  import msp_pkg::*;

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0] sel);
    merge16 = {sel[1] ? new_v[15:8] : old_v[15:8], sel[0] ? new_v[7:0] : old_v[7:0]};
  endfunction

  logic            rst_meta_r;
  logic            rst_n_s;
  msp_pin_t        pin_meta_r;
  msp_pin_t        pin_sync_r;
  logic            ack_r;
  logic [31:0]     dat_r;
  logic [15:0]     ctrl_r;
  logic [15:0]     gpio_r;
  logic [15:0]     rxhold_r;
  logic            done_flag_r;
  logic [15:0]     grp_r [GROUPS];
  logic [15:0]     tx_mem [ENTRIES];
  logic [15:0]     rx_mem [ENTRIES];
  logic [15:0]     ctl_mem [ENTRIES];
  logic [15:0]     st_mem [ENTRIES];
  msp_seq_t        seq_r;
  logic [IDX_W-1:0] cur_r;
  logic [IDX_W-1:0] last_r;
  logic [15:0]     tx_word_r;
  msp_fmt_t        fmt_r;
  logic            sh_busy;
  logic            sh_done;
  logic [15:0]     sh_rx;
  logic            sh_sclk;
  logic            sh_sdo;

  // Reset release through two flops
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_r <= 1'b0;
      rst_n_s    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_s    <= rst_meta_r;
    end
  end

  // Pin inputs pass two flops
  always_ff @(posedge core_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
    end else begin
      pin_meta_r <= pin_in;
      pin_sync_r <= pin_meta_r;
    end
  end

  // Address decode
  wire logic             req      = wb_cyc_i & wb_stb_i & ~ack_r;
  wire logic             wr       = req & wb_we_i;
  wire logic             in_ram   = wb_adr_i[12];
  wire logic [IDX_W-1:0] ram_idx  = wb_adr_i[11:4];
  wire logic [1:0]       ram_fld  = wb_adr_i[3:2];
  wire logic             in_grp   = (wb_adr_i[12:4] == ADR_GRP0[12:4]) & (wb_adr_i[1:0] == 2'h0);
  wire logic [GRP_W-1:0] grp_sel  = wb_adr_i[GRP_W+1:2];
  wire logic             hit_ctrl = wb_adr_i == ADR_CTRL;
  wire logic             hit_stat = wb_adr_i == ADR_STATUS;
  wire logic             hit_trig = wb_adr_i == ADR_TRIG;
  wire logic             hit_rxh  = wb_adr_i == ADR_RXHOLD;
  wire logic             hit_gpio = wb_adr_i == ADR_GPIO;

  // Control decode
  wire logic       port_en   = ctrl_r[CTRL_EN];
  wire logic       is_master = ctrl_r[CTRL_MASTER];
  wire logic [7:0] baud      = ctrl_r[CTRL_BAUD_L +: 8];
  wire logic       seq_idle  = seq_r == SQ_IDLE;
  wire logic       trig_go   = wr & hit_trig & wb_sel_i[0] & seq_idle & port_en;
  wire logic       done_set  = (seq_r == SQ_STORE) & (cur_r == last_r);
  wire logic       done_clr  = wr & hit_stat & wb_sel_i[0] & wb_dat_i[STAT_DONE];

  // Read data selection
  wire logic [15:0] ram_rd = (ram_fld == FLD_TX)  ? tx_mem[ram_idx]  :
                             (ram_fld == FLD_RX)  ? rx_mem[ram_idx]  :
                             (ram_fld == FLD_CTL) ? ctl_mem[ram_idx] : st_mem[ram_idx];
  wire logic [15:0] stat_rd = {cur_r, 6'h00, done_flag_r, ~seq_idle};
  wire logic [15:0] gpio_rd = {5'h00, pin_sync_r, gpio_r[7:0]};
  wire logic [15:0] rd_mux  = in_ram   ? ram_rd          :
                              in_grp   ? grp_r[grp_sel]  :
                              hit_ctrl ? ctrl_r          :
                              hit_stat ? stat_rd         :
                              hit_rxh  ? rxhold_r        :
                              hit_gpio ? gpio_rd         : 16'h0000;

  // Bus answer one cycle after the request; unmapped reads return zero
  always_ff @(posedge core_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= req;
      dat_r <= req ? {16'h0000, rd_mux} : dat_r;
    end
  end

  // Software registers; a finishing group wins over a clear
  always_ff @(posedge core_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      ctrl_r      <= CTRL_RST;
      gpio_r      <= 16'h0000;
      done_flag_r <= 1'b0;
    end else begin
      if (wr && hit_ctrl)
        ctrl_r <= merge16(ctrl_r, wb_dat_i, wb_sel_i);
      if (wr && hit_gpio)
        gpio_r <= merge16(gpio_r, wb_dat_i, wb_sel_i);
      done_flag_r <= done_set | (done_flag_r & ~done_clr);
    end
  end

  // Group boundary registers, first entry low byte and last entry high byte
  genvar g;
  generate
    for (g = 0; g < GROUPS; g++) begin : gen_grp
      always_ff @(posedge core_clk or negedge rst_n_s) begin
        if (!rst_n_s)
          grp_r[g] <= 16'h0000;
        else if (wr && in_grp && grp_sel == GRP_W'(g))
          grp_r[g] <= merge16(grp_r[g], wb_dat_i, wb_sel_i);
      end
    end
  endgenerate

  // Software-owned entry fields
  always_ff @(posedge core_clk) begin
    if (wr && in_ram && ram_fld == FLD_TX)
      tx_mem[ram_idx] <= merge16(tx_mem[ram_idx], wb_dat_i, wb_sel_i);
    if (wr && in_ram && ram_fld == FLD_CTL)
      ctl_mem[ram_idx] <= merge16(ctl_mem[ram_idx], wb_dat_i, wb_sel_i);
  end

  // Hardware-owned entry fields, written as each word completes
  always_ff @(posedge core_clk) begin
    if (seq_r == SQ_STORE) begin
      rx_mem[cur_r] <= rxhold_r;
      st_mem[cur_r] <= ENT_RXVALID;
    end
  end

  // Group sequencer: fetch entry, shift it, store result, advance
  always_ff @(posedge core_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      seq_r     <= SQ_IDLE;
      cur_r     <= 8'h00;
      last_r    <= 8'h00;
      tx_word_r <= 16'h0000;
      fmt_r     <= '0;
      rxhold_r  <= 16'h0000;
    end else begin
      unique case (seq_r)
        SQ_IDLE: begin
          if (trig_go) begin
            cur_r  <= grp_r[wb_dat_i[GRP_W-1:0]][IDX_W-1:0];
            last_r <= grp_r[wb_dat_i[GRP_W-1:0]][15:8];
            seq_r  <= SQ_LOAD;
          end
        end
        SQ_LOAD: begin
          tx_word_r <= tx_mem[cur_r];
          fmt_r     <= ctl_mem[cur_r];
          seq_r     <= SQ_FIRE;
        end
        SQ_FIRE: seq_r <= SQ_RUN;
        SQ_RUN: begin
          if (sh_done) begin
            rxhold_r <= sh_rx;
            seq_r    <= SQ_STORE;
          end
        end
        SQ_STORE: begin
          cur_r <= cur_r + 8'h01;
          seq_r <= (cur_r == last_r) ? SQ_IDLE : SQ_LOAD;
        end
      endcase
    end
  end

  // Word shifter
  msp_shifter i_msp_shifter (
    .core_clk (core_clk),
    .rst_n    (rst_n_s),
    .start    (seq_r == SQ_FIRE),
    .master   (is_master),
    .fmt      (fmt_r),
    .baud     (baud),
    .tx_word  (tx_word_r),
    .busy     (sh_busy),
    .done     (sh_done),
    .rx_word  (sh_rx),
    .sclk_in  (pin_sync_r.serial_shift_clock),
    .sdi      (is_master ? pin_sync_r.master_in_serial_line : pin_sync_r.master_out_serial_line),
    .sclk_out (sh_sclk),
    .sdo      (sh_sdo)
  );

  // Pin roles: serial function when enabled, GPIO otherwise
  wire msp_pin_t fn_out = '{master_in_serial_line: sh_sdo, master_out_serial_line: sh_sdo,
                            serial_shift_clock: sh_sclk};
  wire msp_pin_t fn_oe  = '{master_in_serial_line: ~is_master, master_out_serial_line: is_master,
                            serial_shift_clock: is_master};
  assign pin_out  = port_en ? fn_out : gpio_r[GPIO_OUT_L +: PINS];
  assign pin_oe   = port_en ? fn_oe  : gpio_r[GPIO_DIR_L +: PINS];
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

endmodule

// ==== msp_port_monitor.sv ====
// Purpose: Concurrent checks on the serial port top ports
// Assumes: CTRL and GPIO are written while the port is idle
// Notes:   Shadows follow taken writes per byte lane
`timescale 1ns/1ps
module msp_port_monitor
  import msp_pkg::*;
(
  // Clock and reset
  input wire logic                     core_clk,
  input wire logic                     reset_n,
  // Wishbone
  input wire logic                     wb_cyc_i,
  input wire logic                     wb_stb_i,
  input wire logic                     wb_we_i,
  input wire logic [msp_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0]               wb_sel_i,
  input wire logic [msp_pkg::DAT_W-1:0] wb_dat_i,
  input wire logic [msp_pkg::DAT_W-1:0] wb_dat_o,
  input wire logic                     wb_ack_o,
  // Pins
  input wire msp_pkg::msp_pin_t        pin_out,
  input wire msp_pkg::msp_pin_t        pin_oe
);
  logic        take;
  logic        unm;
  logic        tog;
  logic        sclk_r;
  logic [15:0] lane;
  logic [15:0] ctl_r;
  logic [15:0] gpio_r;
  logic [7:0]  gap_r;
  // Request decode and serial clock change
  assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign unm  = (wb_adr_i > 13'h002c) && (wb_adr_i < ADR_RAM);
  assign lane = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign tog  = pin_out.serial_shift_clock ^ sclk_r;
  // Register shadows and cycles since the last clock change
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctl_r  <= 16'h0000;
      gpio_r <= 16'h0000;
      gap_r  <= 8'h00;
      sclk_r <= 1'b0;
    end else begin
      if (take && wb_we_i && wb_adr_i == ADR_CTRL) ctl_r <= (ctl_r & ~lane) | (wb_dat_i[15:0] & lane);
      if (take && wb_we_i && wb_adr_i == ADR_GPIO) gpio_r <= (gpio_r & ~lane) | (wb_dat_i[15:0] & lane);
      sclk_r <= pin_out.serial_shift_clock;
      gap_r  <= tog ? 8'h00 : (gap_r == 8'hff) ? gap_r : gap_r + 8'h01;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_take; take; endsequence
  sequence s_pulse; ##1 wb_ack_o ##1 !wb_ack_o; endsequence
  property p_ack; s_take |-> s_pulse; endproperty
  property p_cause; wb_ack_o |-> $past(take); endproperty
  property p_hi; wb_ack_o |-> wb_dat_o[31:16] == 16'h0000; endproperty
  property p_unm; s_take ##0 (!wb_we_i && unm) |=> wb_dat_o == 32'h0; endproperty
  property p_rate; ctl_r[1:0] == 2'b11 && $stable(ctl_r) && tog |-> gap_r >= ctl_r[15:8]; endproperty
  property p_mst; ctl_r[1:0] == 2'b11 && $stable(ctl_r) |-> pin_oe == 3'b011; endproperty
  property p_slv; ctl_r[1:0] == 2'b01 && $stable(ctl_r) |-> pin_oe == 3'b100; endproperty
  property p_gpio; !ctl_r[0] && $stable(ctl_r) && $stable(gpio_r)
    |-> pin_oe == gpio_r[6:4] && (pin_out & pin_oe) == (gpio_r[2:0] & gpio_r[6:4]); endproperty
  a_ack: assert property (p_ack) else $error("ack not a single pulse after request");
  a_cause: assert property (p_cause) else $error("ack without request");
  a_hi: assert property (p_hi) else $error("upper read lanes not zero");
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  a_rate: assert property (p_rate) else $error("serial clock edges closer than baud");
  a_mst: assert property (p_mst) else $error("master pin drive wrong");
  a_slv: assert property (p_slv) else $error("slave pin drive wrong");
  a_gpio: assert property (p_gpio) else $error("gpio pins wrong");
endmodule
bind msp_port msp_port_monitor i_msp_port_monitor (.core_clk(core_clk), .reset_n(reset_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_out(pin_out), .pin_oe(pin_oe));

// ==== msp_peer.sv ====
// Purpose: Far-side serial device following the port clock
// Assumes: Format is set before each trigger
// Notes:   Word ends after twice its length of clock edges
`timescale 1ns/1ps
module msp_peer (
  // Serial lines
  input  wire logic        sclk,
  input  wire logic        mosi,
  output logic             miso,
  // Word format and data
  input  wire logic [3:0]  len_m1,
  input  wire logic        cpol,
  input  wire logic        cpha,
  input  wire logic [15:0] tx,
  output logic [15:0]      got
);
  logic [15:0] sh;
  logic [15:0] log_q[$];
  int          lm;
  int          edges;
  int          k;
  // Code 0 shifts two bits; output index skips first leading edge with cpha
  assign lm   = (len_m1 == 4'h0) ? 1 : int'(len_m1);
  assign k    = cpha ? ((edges == 0) ? 0 : (edges - 1) / 2) : edges / 2;
  assign miso = tx[lm - k];
  initial begin
    sh = 16'h0000;
    edges = 0;
    got = 16'h0000;
  end
  // Sample on the format's edge; a move to idle level before the first edge is no edge
  always @(sclk) begin
    if (edges != 0 || sclk != cpol) begin
      if ((sclk != cpol) != cpha) sh = {sh[14:0], mosi};
      edges = edges + 1;
      if (edges == 2 * (lm + 1)) begin
        got = sh;
        log_q.push_back(sh);
        sh = 16'h0000;
        edges = 0;
      end
    end
  end
endmodule

// ==== msp_port_bench.sv ====
// Purpose: Self-checking bench for the multibuffer serial port
// Assumes: Peer on the far side; master runs at baud 3
// Notes:   Half bit is four core cycles
`timescale 1ns/1ps
module msp_port_bench;
  import msp_pkg::*;
  logic             core_clk;
  logic             reset_n;
  logic             cyc;
  logic             stb;
  logic             we;
  logic [12:0]      adr;
  logic [3:0]       sel;
  logic [31:0]      wdat;
  logic [31:0]      rdat;
  logic             ack;
  msp_pin_t         pin_in;
  msp_pin_t         pin_out;
  msp_pin_t         pin_oe;
  logic [1:0]       ext;
  logic             miso;
  logic [3:0]       p_len;
  logic             p_cpol;
  logic             p_cpha;
  logic [15:0]      p_tx;
  logic [15:0]      p_got;
  logic [31:0]      q;
  int               bad_count;
  int               n_checks;
  logic [7:0]       ents [4] = '{8'hff, 8'h00, 8'h80, 8'h11};
  logic [15:0]      ctls [4] = '{16'h000f, 16'h0030, 16'h0027, 16'h0013};
  logic [15:0]      txs  [4] = '{16'ha5c3, 16'h0002, 16'h005a, 16'h0009};
  logic [15:0]      pxs  [4] = '{16'h3c5a, 16'h0001, 16'h00b7, 16'h000e};
  // Wire level: driven pins win, else peer or bench level
  assign pin_in = msp_pin_t'((pin_out & pin_oe) | ({miso, ext} & ~pin_oe));
  msp_port i_msp_port (.core_clk(core_clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
  msp_peer i_msp_peer (.sclk(pin_in.serial_shift_clock), .mosi(pin_in.master_out_serial_line), .miso(miso),
    .len_m1(p_len), .cpol(p_cpol), .cpha(p_cpha), .tx(p_tx), .got(p_got));
  // One classic cycle, held until ack, then one idle cycle
  task automatic bus(input logic w, input logic [12:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge core_clk);
    while (ack !== 1'b1 && n < 50) begin
      @(posedge core_clk);
      n++;
    end
    q = rdat;
    if (n == 50) bad_count++;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rc(input string nm, input logic [12:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask
  function automatic logic [12:0] ea(input logic [7:0] e, input logic [1:0] f);
    return ADR_RAM + {1'b0, e, f, 2'b00};
  endfunction
  // Clear done, start a group, poll until done
  task automatic go(input logic [1:0] g);
    int n;
    n = 0;
    bus(1'b1, ADR_STATUS, 32'h2);
    bus(1'b1, ADR_TRIG, {30'h0, g});
    q = 32'h0;
    while (q[STAT_DONE] !== 1'b1 && n < 300) begin
      bus(1'b0, ADR_STATUS, 32'h0);
      n++;
    end
    if (n == 300) bad_count++;
    chk("busy", 32'h0, {31'h0, q[STAT_BUSY]});
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    repeat (40000) @(posedge core_clk);
    bad_count++;
    wrap_up();
  end
  // Main sequence
  initial begin
    logic [7:0]  e;
    int          lm;
    int          n0;
    logic [15:0] mk;
    logic [3:0]  so;
    logic [3:0]  sd;
    reset_n = 1'b0;
    {cyc, stb, we, adr, wdat, ext} = '0;
    sel = 4'hf;
    {p_len, p_cpol, p_cpha, p_tx} = {4'hf, 2'b00, 16'ha5c3};
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    rc("ctrl reset", ADR_CTRL, 32'h0);
    rc("unmapped", 13'h0040, 32'h0);
    $display("reset test done");
    bus(1'b1, ADR_GPIO, 32'h0022);
    repeat (4) @(posedge core_clk);
    chk("gpio oe", 32'h2, {29'h0, pin_oe});
    rc("gpio", ADR_GPIO, 32'h0622);
    $display("gpio test done");
    bus(1'b1, ADR_CTRL, 32'h0303);
    for (int i = 0; i < 4; i++) begin
      e = ents[i];
      lm = (ctls[i][3:0] == 4'h0) ? 1 : int'(ctls[i][3:0]);
      mk = 16'((32'h1 << (lm + 1)) - 1);
      bus(1'b1, ea(e, FLD_TX), {16'h0, txs[i]});
      bus(1'b1, ea(e, FLD_CTL), {16'h0, ctls[i]});
      bus(1'b1, ADR_GRP0, {16'h0, e, e});
      {p_len, p_cpol, p_cpha, p_tx} <= {ctls[i][3:0], ctls[i][4], ctls[i][5], pxs[i]};
      go(2'h0);
      rc("rx field", ea(e, FLD_RX), {16'h0, pxs[i] & mk});
      rc("entry status", ea(e, FLD_STAT), 32'h1);
      rc("rx hold", ADR_RXHOLD, {16'h0, pxs[i] & mk});
      chk("peer word", {16'h0, txs[i] & mk}, {16'h0, p_got});
      rc("tx field", ea(e, FLD_TX), {16'h0, txs[i]});
    end
    bus(1'b1, ea(8'hff, FLD_RX), 32'hffff);
    bus(1'b1, ea(8'hff, FLD_STAT), 32'h0);
    rc("rx read only", ea(8'hff, FLD_RX), 32'h3c5a);
    rc("status read only", ea(8'hff, FLD_STAT), 32'h1);
    $display("format test done");
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, ea(8'hfe + 8'(k), FLD_TX), 32'h11 * (k + 1));
      bus(1'b1, ea(8'hfe + 8'(k), FLD_CTL), 32'h0007);
    end
    bus(1'b1, ADR_GRP0 + 13'h0008, 32'h01fe);
    {p_len, p_cpol, p_cpha, p_tx} <= {4'h7, 2'b00, 16'h00c3};
    n0 = i_msp_peer.log_q.size();
    go(2'h2);
    for (int k = 0; k < 4; k++) begin
      rc("group rx", ea(8'hfe + 8'(k), FLD_RX), 32'h00c3);
      chk("group order", 32'h11 * (k + 1), {16'h0, i_msp_peer.log_q[n0 + k]});
    end
    $display("group test done");
    bus(1'b1, ADR_CTRL, 32'h0301);
    repeat (2) @(posedge core_clk);
    chk("slave oe", 32'h4, {29'h0, pin_oe});
    // Slave word: bench is the clock master, 4 bits, clock phase 0, six-cycle half periods
    sd = 4'h5;
    so = 4'h0;
    bus(1'b1, ea(8'h40, FLD_TX), 32'h000a);
    bus(1'b1, ea(8'h40, FLD_CTL), 32'h0003);
    bus(1'b1, ADR_GRP0, 32'h4040);
    bus(1'b1, ADR_STATUS, 32'h2);
    bus(1'b1, ADR_TRIG, 32'h0);
    for (int b = 3; b >= 0; b--) begin
      ext <= {sd[b], 1'b0};
      repeat (6) @(posedge core_clk);
      so = {so[2:0], pin_out.master_in_serial_line};
      ext <= {sd[b], 1'b1};
      repeat (6) @(posedge core_clk);
    end
    ext <= 2'b00;
    repeat (20) @(posedge core_clk);
    rc("slave rx", ea(8'h40, FLD_RX), 32'h0005);
    chk("slave tx", 32'ha, {28'h0, so});
    bus(1'b0, ADR_STATUS, 32'h0);
    chk("slave done", 32'h2, q & 32'h3);
    // Trigger with the port disabled must start nothing
    bus(1'b1, ADR_CTRL, 32'h0);
    bus(1'b1, ADR_STATUS, 32'h2);
    bus(1'b1, ADR_TRIG, 32'h0);
    repeat (20) @(posedge core_clk);
    bus(1'b0, ADR_STATUS, 32'h0);
    chk("idle trigger", 32'h0, q & 32'h3);
    $display("mode test done");
    wrap_up();
  end
endmodule
